// file: async_serial_tx_rx.sv
// serial port top: axi4-lite register slave, baud generator, holding
// buffer, receive fifo; instantiates the transmit and receive engines
// assumes serial pins already synchronous to clk
`timescale 1ns/100ps
module async_serial_tx_rx
  import uart_pkg::*;
#(
  parameter int ADDR_W     = 10,
  parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output wire logic              s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output wire logic              s_axi_wready,
  // axi4-lite write response
  output wire logic [1:0]        s_axi_bresp,
  output wire logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output wire logic              s_axi_arready,
  // axi4-lite read data
  output wire logic [31:0]       s_axi_rdata,
  output wire logic [1:0]        s_axi_rresp,
  output wire logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // serial pins
  output wire logic              transmit_pin_out,
  output wire logic              transmit_pin_oe,
  input  wire logic              receive_pin_in,
  // interrupt requests towards the interrupt controller
  output wire logic              tx_irq_req,
  output wire logic              rx_irq_req
);
  localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int CNT_W = PTR_W + 1;
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(FIFO_DEPTH);

  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [7:0]        idx);
    reg_hit = (addr[1:0] == 2'b00) && (addr[ADDR_W-1:2] == idx);
  endfunction

  function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
    reg_mapped = reg_hit(addr, IDX_IRQ_FLAGS)   ||
                 reg_hit(addr, IDX_RX_STATUS)   ||
                 reg_hit(addr, IDX_TX_HOLD)     ||
                 reg_hit(addr, IDX_RX_HEAD)     ||
                 reg_hit(addr, IDX_IRQ_ENABLES) ||
                 reg_hit(addr, IDX_TX_STATUS)   ||
                 reg_hit(addr, IDX_BAUD_DIV);
  endfunction

  serial_core_if core ();

  // bus state
  logic              aw_held_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic              w_held_ff;
  logic [7:0]        w_data_ff;
  logic              w_lane0_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              rvalid_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        rresp_ff;
  logic              do_write;
  logic              do_read;
  logic              wr_byte;
  // software registers
  logic [7:0]        pie_ff;
  logic [7:0]        transmit_status_control_ff;
  logic [7:0]        receive_status_control_ff;
  logic [7:0]        baud_div_ff;
  logic [7:0]        hold_data_ff;
  logic              hold_full_ff;
  // baud generator
  logic [7:0]        baud_cnt_ff;
  logic [1:0]        prescale_ff;
  logic              baud_tick;
  // receive fifo
  logic [9:0]        fifo_ff [FIFO_DEPTH];
  logic [PTR_W-1:0]  wr_ptr_ff;
  logic [PTR_W-1:0]  rd_ptr_ff;
  logic [CNT_W-1:0]  count_ff;
  logic              overrun_error_ff;
  logic              push;
  logic              pop;
  logic [9:0]        head;
  // status
  logic              serial_port_enable;
  logic              tx_flag;
  logic              rx_flag;
  logic [7:0]        flags_rd;
  logic [7:0]        transmit_status_control_rd;
  logic [7:0]        receive_status_control_rd;
  logic [7:0]        rd_byte;

  // axi4-lite write path: address and data taken in either order
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready  = !w_held_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign do_write      = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_byte       = do_write && w_lane0_ff;

  always_ff @(posedge clk) begin
    if (reset) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff <= 1'b1;
      aw_addr_ff <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      w_held_ff  <= 1'b0;
      w_data_ff  <= 8'h00;
      w_lane0_ff <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff  <= 1'b1;
      w_data_ff  <= s_axi_wdata[7:0];
      w_lane0_ff <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= reg_mapped(aw_addr_ff) ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // axi4-lite read path: one read in flight, data registered
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign do_read       = s_axi_arvalid && !rvalid_ff;

  always_comb begin
    rd_byte = 8'h00;
    if (reg_hit(s_axi_araddr, IDX_IRQ_FLAGS))   rd_byte = flags_rd;
    if (reg_hit(s_axi_araddr, IDX_RX_STATUS))   rd_byte = receive_status_control_rd;
    if (reg_hit(s_axi_araddr, IDX_TX_HOLD))     rd_byte = hold_data_ff;
    if (reg_hit(s_axi_araddr, IDX_RX_HEAD))     rd_byte = head[7:0];
    if (reg_hit(s_axi_araddr, IDX_IRQ_ENABLES)) rd_byte = pie_ff;
    if (reg_hit(s_axi_araddr, IDX_TX_STATUS))   rd_byte = transmit_status_control_rd;
    if (reg_hit(s_axi_araddr, IDX_BAUD_DIV))    rd_byte = baud_div_ff;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= RESP_OKAY;
    end else if (do_read) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= {24'h00_0000, rd_byte};
      rresp_ff  <= reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // control registers; status bits are composed at read time
  always_ff @(posedge clk) begin
    if (reset) begin
      pie_ff      <= RST_PIE;
      transmit_status_control_ff    <= RST_TRANSMIT_STATUS_CONTROL & TX_WR_MASK;
      receive_status_control_ff    <= RST_RECEIVE_STATUS_CONTROL;
      baud_div_ff <= RST_BAUD;
    end else if (wr_byte) begin
      if (reg_hit(aw_addr_ff, IDX_IRQ_ENABLES)) pie_ff <= w_data_ff;
      if (reg_hit(aw_addr_ff, IDX_TX_STATUS))
        transmit_status_control_ff <= w_data_ff & TX_WR_MASK;
      if (reg_hit(aw_addr_ff, IDX_RX_STATUS))
        receive_status_control_ff <= w_data_ff & RC_WR_MASK;
      if (reg_hit(aw_addr_ff, IDX_BAUD_DIV)) baud_div_ff <= w_data_ff;
    end
  end

  // holding buffer; a write in the same cycle as a handoff wins
  always_ff @(posedge clk) begin
    if (reset) begin
      hold_data_ff <= RST_TXHOLD;
      hold_full_ff <= 1'b0;
    end else if (wr_byte && reg_hit(aw_addr_ff, IDX_TX_HOLD)) begin
      hold_data_ff <= w_data_ff;
      hold_full_ff <= 1'b1;
    end else if (core.tx_take) begin
      hold_full_ff <= 1'b0;
    end
  end

  // baud generator: divisor+1 clocks per tick, tick is x16 or x64
  assign serial_port_enable      = receive_status_control_ff[RC_SERIAL_PORT_ENABLE];
  assign baud_tick = serial_port_enable && (baud_cnt_ff == baud_div_ff);

  always_ff @(posedge clk) begin
    if (reset || !serial_port_enable) begin
      baud_cnt_ff <= 8'h00;
      prescale_ff <= 2'h0;
    end else begin
      baud_cnt_ff <= baud_tick ? 8'h00 : baud_cnt_ff + 8'h01;
      if (baud_tick) begin
        prescale_ff <= prescale_ff + 2'h1;
      end
    end
  end

  // the x64 tick is divided by four so both engines see x16
  assign core.tick16 = baud_tick &&
                       (transmit_status_control_ff[TX_HIGH_SPEED_SELECT] ||
                        prescale_ff == PRESCALE_LAST);

  // transmitter hookup
  assign core.tx_en      = serial_port_enable && transmit_status_control_ff[TX_TX_ENABLE];
  assign core.tx_nine    = transmit_status_control_ff[TX_TX9];
  assign core.hold_valid = hold_full_ff;
  assign core.hold_data  = hold_data_ff;
  // ninth bit is taken at handoff, so a late write sends a stale bit
  assign core.hold_ninth = transmit_status_control_ff[TX_TX_NINTH_BIT];
  assign tx_flag         = core.tx_en && !hold_full_ff;
  assign tx_irq_req      = tx_flag && pie_ff[FLG_TX_EMPTY];
  assign transmit_pin_out = core.tx_out;
  assign transmit_pin_oe  = core.tx_en;

  serial_tx_engine u_tx (
    .clk   (clk),
    .reset (reset),
    .core  (core.tx_end)
  );

  // receiver hookup
  assign core.rx_en   = serial_port_enable && receive_status_control_ff[RC_CONTINUOUS_RX_ENABLE];
  assign core.rx_nine = receive_status_control_ff[RC_RX9];
  assign core.rx_in   = receive_pin_in;

  serial_rx_engine u_rx (
    .clk   (clk),
    .reset (reset),
    .core  (core.rx_end)
  );

  // receive fifo; entry is {framing error, ninth bit, data}
  assign push = core.rx_done && !overrun_error_ff &&
                (count_ff != CNT_FULL);
  assign pop  = do_read && reg_hit(s_axi_araddr, IDX_RX_HEAD) &&
                (count_ff != '0);
  assign head = fifo_ff[rd_ptr_ff];

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        fifo_ff[i] <= 10'h000;
      end
    end else if (push) begin
      fifo_ff[wr_ptr_ff] <= {core.rx_framing_error, core.rx_ninth,
                             core.rx_data};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == PTR_W'(FIFO_DEPTH - 1)) ? '0
                     : wr_ptr_ff + PTR_W'(1);
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == PTR_W'(FIFO_DEPTH - 1)) ? '0
                     : rd_ptr_ff + PTR_W'(1);
      end
      count_ff <= count_ff + CNT_W'(push) - CNT_W'(pop);
    end
  end

  // overrun sticks until the receiver is disabled
  always_ff @(posedge clk) begin
    if (reset || !core.rx_en) begin
      overrun_error_ff <= 1'b0;
    end else if (core.rx_done && count_ff == CNT_FULL) begin
      overrun_error_ff <= 1'b1;
    end
  end

  assign rx_flag    = (count_ff != '0);
  assign rx_irq_req = rx_flag && pie_ff[FLG_RX_AVAIL];

  always_comb begin
    flags_rd = 8'h00;
    flags_rd[FLG_RX_AVAIL] = rx_flag;
    flags_rd[FLG_TX_EMPTY] = tx_flag;
    transmit_status_control_rd = transmit_status_control_ff;
    transmit_status_control_rd[TX_TX_SHIFTER_EMPTY] = core.tx_idle;
    receive_status_control_rd = receive_status_control_ff;
    receive_status_control_rd[RC_FRAMING_ERROR] = head[9];
    receive_status_control_rd[RC_OVERRUN_ERROR] = overrun_error_ff;
    receive_status_control_rd[RC_RX_NINTH_BIT] = head[8];
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_hold_write;
    wr_byte && reg_hit(aw_addr_ff, IDX_TX_HOLD);
  endsequence

  sequence s_idle_load;
    core.tx_en && hold_full_ff && core.tx_idle;
  endsequence

  sequence s_rx_full_stop;
    core.rx_done && count_ff == CNT_FULL;
  endsequence

  a_tx_flag_clear: assert property (s_hold_write |=> !tx_flag)
    else $error("buffer-empty flag not cleared by buffer write");

  a_tx_immediate: assert property (s_idle_load |=> !core.tx_idle &&
                                   !hold_full_ff ##1 tx_flag)
    else $error("idle shifter did not take the buffered byte");

  a_tx_enable_flag: assert property ($rose(core.tx_en) &&
                                     !hold_full_ff |-> tx_flag)
    else $error("enabling transmitter did not raise empty flag");

  a_tx_abort: assert property ($fell(core.tx_en) |=>
                               core.tx_idle && !transmit_pin_oe)
    else $error("transmitter not reset after disable");

  a_tx_irq_gate: assert property (tx_irq_req |->
                                  pie_ff[FLG_TX_EMPTY] && tx_flag)
    else $error("transmit request without enable");

  a_rx_irq_gate: assert property (rx_irq_req |->
                                  pie_ff[FLG_RX_AVAIL] && rx_flag)
    else $error("receive request without enable");

  a_rx_push_flag: assert property (push |=> rx_flag &&
                                   $past(core.rx_data) == fifo_ff[
                                   $past(wr_ptr_ff)][7:0])
    else $error("received byte not stored or flag not set");

  a_rx_flag_clear: assert property (count_ff == CNT_W'(1) && pop &&
                                    !push |=> !rx_flag)
    else $error("receive flag stayed set on empty fifo");

  a_rx_overrun: assert property (s_rx_full_stop |=> overrun_error_ff &&
                                 count_ff == CNT_FULL -
                                 CNT_W'($past(pop)))
    else $error("overrun not flagged or byte not dropped");

  a_rx_blocked: assert property (overrun_error_ff && core.rx_en |->
                                 !push ##1 overrun_error_ff)
    else $error("transfer while overrun set");

  a_fifo_bound: assert property (count_ff <= CNT_FULL)
    else $error("receive fifo count beyond depth");

  a_rx_disabled: assert property (!core.rx_en |=> !core.rx_done)
    else $error("reception while receive disabled");
endmodule

// file: serial_core_if.sv
// signals between the register core and the two serial engines
// assumes all three parties run on the same clock
`timescale 1ns/100ps
interface serial_core_if;
  logic       tick16;
  logic       tx_en;
  logic       tx_nine;
  logic       hold_valid;
  logic [7:0] hold_data;
  logic       hold_ninth;
  logic       tx_take;
  logic       tx_out;
  logic       tx_idle;
  logic       rx_en;
  logic       rx_nine;
  logic       rx_in;
  logic       rx_done;
  logic [7:0] rx_data;
  logic       rx_ninth;
  logic       rx_framing_error;
  modport ctl (output tick16, tx_en, tx_nine, hold_valid, hold_data,
               hold_ninth, rx_en, rx_nine, rx_in,
               input tx_take, tx_out, tx_idle, rx_done, rx_data,
               rx_ninth, rx_framing_error);
  modport tx_end (input tick16, tx_en, tx_nine, hold_valid, hold_data,
                  hold_ninth, output tx_take, tx_out, tx_idle);
  modport rx_end (input tick16, rx_en, rx_nine, rx_in,
                  output rx_done, rx_data, rx_ninth, rx_framing_error);
endinterface

// file: serial_peer.sv
// serial peer: sends frames to the receive pin, collects transmitted bytes
// assumes one bit cell is BIT clocks; collects eight data bits and the
// cell after them, which is the ninth bit or, in 8-bit frames, the stop
`timescale 1ns/100ps
module serial_peer #(
  parameter int BIT = 16
) (
  // clock
  input  wire logic clk,
  // serial lines
  input  wire logic line_in,
  input  wire logic line_oe,
  output logic      line_out,
  // collected byte
  output logic      got,
  output logic [8:0] got_byte
);
  initial begin
    line_out = 1'b1;
    got = 1'b0;
    got_byte = 9'h000;
  end
  // start low, data lsb first, then stop; idle gap so a low stop is not
  // mistaken for the next start edge
  task send(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= f[i];
      repeat (BIT) @(posedge clk);
    end
    line_out <= 1'b1;
    repeat (BIT) @(posedge clk);
  endtask
  // sample mid-cell; ignore the pin while it is not driven
  always begin
    @(posedge clk);
    if (line_oe && !line_in) begin
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT) @(posedge clk);
        got_byte[i] <= line_in;
      end
      got <= 1'b1;
      @(posedge clk);
      got <= 1'b0;
    end
  end
endmodule

// file: serial_rx_engine.sv
// receive shifter: finds the start edge, samples each bit mid-cell
// assumes tick16 pulses at sixteen times the bit rate, line synchronous
`timescale 1ns/100ps
module serial_rx_engine
  import uart_pkg::*;
(
  // clock and reset
  input wire logic      clk,
  input wire logic      reset,
  // core side
  serial_core_if.rx_end core
);
  typedef enum logic {RX_IDLE, RX_BUSY} rx_state_t;
  rx_state_t  state_ff;
  logic [3:0] phase_ff;
  logic [3:0] idx_ff;
  logic [8:0] sr_ff;
  logic       done_ff;
  logic [7:0] data_ff;
  logic       ninth_ff;
  logic       framing_error_ff;
  logic       armed_ff;
  logic [3:0] nbits;

  assign nbits         = core.rx_nine ? 4'h9 : 4'h8;
  assign core.rx_done  = done_ff;
  assign core.rx_data  = data_ff;
  assign core.rx_ninth = ninth_ff;
  assign core.rx_framing_error  = framing_error_ff;

  always_ff @(posedge clk) begin
    if (reset || !core.rx_en) begin
      state_ff <= RX_IDLE;
      phase_ff <= 4'h0;
      idx_ff   <= 4'h0;
      sr_ff    <= 9'h000;
      done_ff  <= 1'b0;
      data_ff  <= 8'h00;
      ninth_ff <= 1'b0;
      framing_error_ff  <= 1'b0;
      armed_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (core.tick16) begin
        if (state_ff == RX_IDLE) begin
          // a start needs a high line first, so the tail of a low stop
          // bit is never taken for the next start
          if (!core.rx_in && armed_ff) begin
            state_ff <= RX_BUSY;
            phase_ff <= 4'h0;
            idx_ff   <= 4'h0;
            armed_ff <= 1'b0;
          end else if (core.rx_in) begin
            armed_ff <= 1'b1;
          end
        end else begin
          phase_ff <= phase_ff + 4'h1;
          if (phase_ff == PHASE_MID) begin
            idx_ff <= idx_ff + 4'h1;
            if (idx_ff == 4'h0 && core.rx_in) begin
              // glitch shorter than half a bit is not a start
              state_ff <= RX_IDLE;
            end else if (idx_ff == nbits + 4'h1) begin
              state_ff <= RX_IDLE;
              done_ff  <= 1'b1;
              framing_error_ff  <= !core.rx_in;
              data_ff  <= core.rx_nine ? sr_ff[7:0] : sr_ff[8:1];
              ninth_ff <= core.rx_nine & sr_ff[8];
            end else if (idx_ff != 4'h0) begin
              sr_ff <= {core.rx_in, sr_ff[8:1]};
            end
          end
        end
      end
    end
  end
endmodule

// file: serial_tx_engine.sv
// transmit shifter: start bit, 8 or 9 data bits lsb first, stop bit
// assumes tick16 pulses at sixteen times the bit rate
`timescale 1ns/100ps
module serial_tx_engine
  import uart_pkg::*;
(
  // clock and reset
  input wire logic      clk,
  input wire logic      reset,
  // core side
  serial_core_if.tx_end core
);
  typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;
  tx_state_t   state_ff;
  logic [10:0] frame_ff;
  logic [3:0]  bits_left_ff;
  logic [3:0]  phase_ff;
  logic        bit_end;
  logic        take;

  assign bit_end = core.tick16 && (phase_ff == PHASE_LAST);
  // reload only at the idle state or at the very end of the stop bit
  assign take = core.tx_en && core.hold_valid &&
                (state_ff == TX_IDLE || (bit_end && bits_left_ff == 4'h1));
  assign core.tx_take = take;
  assign core.tx_idle = (state_ff == TX_IDLE);
  assign core.tx_out  = (state_ff == TX_IDLE) ? 1'b1 : frame_ff[0];

  always_ff @(posedge clk) begin
    if (reset || !core.tx_en) begin
      state_ff     <= TX_IDLE;
      frame_ff     <= '1;
      bits_left_ff <= 4'h0;
      phase_ff     <= 4'h0;
    end else if (take) begin
      state_ff     <= TX_SHIFT;
      frame_ff     <= {1'b1, core.tx_nine ? core.hold_ninth : 1'b1,
                       core.hold_data, 1'b0};
      bits_left_ff <= core.tx_nine ? FRAME_BITS9 : FRAME_BITS8;
      phase_ff     <= 4'h0;
    end else if (state_ff == TX_SHIFT && core.tick16) begin
      phase_ff <= phase_ff + 4'h1;
      if (bit_end) begin
        frame_ff     <= {1'b1, frame_ff[10:1]};
        bits_left_ff <= bits_left_ff - 4'h1;
        if (bits_left_ff == 4'h1) begin
          state_ff <= TX_IDLE;
        end
      end
    end
  end
endmodule

// file: tb_top.sv
// testbench: registers over axi4-lite, serial traffic through serial_peer
// assumes baud_divisor 0 with high speed, so one bit is 16 clocks
`timescale 1ns/100ps
module tb_top;
  import uart_pkg::*;
  // bready and rready stay high, so every answer is taken when it appears
  logic        clk = 0, reset = 1, awvalid = 0, wvalid = 0, bready = 1;
  logic        arvalid = 0, rready = 1, awready, wready, bvalid, arready;
  logic        rvalid, txd, txoe, rxd, got;
  logic [9:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, seed = 32'h8234;
  logic [7:0]  rq[$];
  logic [8:0]  gbyte, tq[$];
  int          err_count = 0, check_count = 0;
  always #10 clk = ~clk;
  async_serial_tx_rx async_serial_tx_rx_i (.clk, .reset,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .transmit_pin_out(txd), .transmit_pin_oe(txoe), .receive_pin_in(rxd),
    .tx_irq_req(), .rx_irq_req());
  serial_peer serial_peer_i (.clk, .line_in(txd), .line_oe(txoe),
    .line_out(rxd), .got, .got_byte(gbyte));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task cmp(string n, logic [8:0] e, logic [8:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // ready sampled at the rising edge; each channel drops once taken
  task wr(logic [7:0] i, logic [7:0] d);
    awaddr <= {i, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
  endtask
  task rd(logic [7:0] i, logic [7:0] e);
    rq.push_back(e);
    araddr <= {i, 2'b00};
    arvalid <= 1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
  endtask
  always @(posedge clk) begin
    if (rvalid & rready) cmp("register", rq.pop_front(), rdata[7:0]);
    if (got) cmp("serial byte", tq.pop_front(), gbyte);
  end
  task print_verdict;
    if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    print_verdict;
  end
  initial begin
    logic [7:0] b[3];
    repeat (4) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    foreach (b[k]) b[k] = rnd();
    rd(IDX_TX_STATUS, RST_TRANSMIT_STATUS_CONTROL);
    rd(IDX_IRQ_FLAGS, 8'h00);
    rd(8'h01, 8'h00);
    wr(IDX_BAUD_DIV, 8'h00);
    wr(IDX_RX_STATUS, 8'h90);
    wr(IDX_TX_STATUS, 8'h24);
    rd(IDX_IRQ_FLAGS, 8'h10);
    tq.push_back({1'b1, b[0]});
    tq.push_back({1'b1, b[1]});
    wr(IDX_TX_HOLD, b[0]);
    wr(IDX_TX_HOLD, b[1]);
    rd(IDX_IRQ_FLAGS, 8'h00);
    rd(IDX_TX_STATUS, 8'h24);
    serial_peer_i.send(b[0], 1'b1);
    serial_peer_i.send(b[1], 1'b0);
    serial_peer_i.send(b[2], 1'b1);
    repeat (20) @(posedge clk);
    rd(IDX_RX_STATUS, 8'h92);
    rd(IDX_RX_HEAD, b[0]);
    rd(IDX_RX_STATUS, 8'h96);
    rd(IDX_RX_HEAD, b[1]);
    rd(IDX_IRQ_FLAGS, 8'h10);
    wr(IDX_RX_STATUS, 8'h80);
    wr(IDX_RX_STATUS, 8'h90);
    rd(IDX_RX_STATUS, 8'h90);
    wr(IDX_RX_STATUS, 8'hd0);
    wr(IDX_TX_STATUS, 8'h65);
    tq.push_back({1'b1, b[2]});
    wr(IDX_TX_HOLD, b[2]);
    // the stop argument is the ninth bit here; the idle gap is the stop
    serial_peer_i.send(b[2], 1'b1);
    repeat (20) @(posedge clk);
    rd(IDX_RX_STATUS, 8'hd1);
    rd(IDX_RX_HEAD, b[2]);
    cmp("frames left", 9'h000, 9'(tq.size()));
    print_verdict;
  end
endmodule

// file: uart_pkg.sv
// register map, field positions, reset values and counts of the serial port
// assumes one 50 MHz clock and a synchronous active-high reset
// How it works
// - shifter reloads only after previous stop bit
// - buffer handoff takes one cycle, flag rises
// - buffer-empty flag cleared by buffer write or transmitter disable
// - transmit request gated by its enable bit
// - shifter-empty bit readable, polled, no request
// - enabling transmitter sets buffer-empty flag at once
// - send needs enable, data and baud tick
// - idle shifter takes written byte immediately
// - disabling transmitter aborts frame, releases pin
// - receiver samples line at sixteen times rate
// - reception only while continuous receive enabled
// - after stop bit, push to fifo, flag
// - receive request gated by its enable bit
// - receive flag clears when fifo read empty
// - two-entry fifo, third byte may shift in
// - full fifo at stop sets overrun, drops
// - overrun blocks transfers until receive re-enabled
// - zero stop bit sets framing error
// - framing and ninth bits travel with data
// - nrz frame, lsb first, shared format
// - baud tick at x16 or x64 rate
package uart_pkg;
  // printed offsets are word indices; byte address is four times the index
  localparam logic [7:0] IDX_IRQ_FLAGS   = 8'h0c;
  localparam logic [7:0] IDX_RX_STATUS   = 8'h18;
  localparam logic [7:0] IDX_TX_HOLD     = 8'h19;
  localparam logic [7:0] IDX_RX_HEAD     = 8'h1a;
  localparam logic [7:0] IDX_IRQ_ENABLES = 8'h8c;
  localparam logic [7:0] IDX_TX_STATUS   = 8'h98;
  localparam logic [7:0] IDX_BAUD_DIV    = 8'h99;
  localparam int FLG_RX_AVAIL = 5;
  localparam int FLG_TX_EMPTY = 4;
  localparam int RC_SERIAL_PORT_ENABLE = 7;
  localparam int RC_RX9  = 6;
  localparam int RC_CONTINUOUS_RX_ENABLE = 4;
  localparam int RC_FRAMING_ERROR = 2;
  localparam int RC_OVERRUN_ERROR = 1;
  localparam int RC_RX_NINTH_BIT = 0;
  localparam int TX_TX9  = 6;
  localparam int TX_TX_ENABLE = 5;
  localparam int TX_HIGH_SPEED_SELECT = 2;
  localparam int TX_TX_SHIFTER_EMPTY = 1;
  localparam int TX_TX_NINTH_BIT = 0;
  localparam logic [7:0] RC_WR_MASK  = 8'hf8;
  localparam logic [7:0] TX_WR_MASK  = 8'hf5;
  localparam logic [7:0] RST_PIE     = 8'h00;
  localparam logic [7:0] RST_RECEIVE_STATUS_CONTROL   = 8'h00;
  localparam logic [7:0] RST_TRANSMIT_STATUS_CONTROL   = 8'h02;
  localparam logic [7:0] RST_TXHOLD  = 8'h00;
  localparam logic [7:0] RST_BAUD    = 8'h00;
  localparam logic [1:0] PRESCALE_LAST = 2'h3;
  localparam logic [3:0] PHASE_MID   = 4'h7;
  localparam logic [3:0] PHASE_LAST  = 4'hf;
  localparam logic [3:0] FRAME_BITS8 = 4'ha;
  localparam logic [3:0] FRAME_BITS9 = 4'hb;
  localparam int RX_FIFO_DEPTH = 2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage
